// >>> design/sad_dec_if.sv
`timescale 1ns/1ps
interface sad_dec_if;
  import sad_pkg::*;
  logic [31:0] addr;
  sad_cycle_e cycle;
  logic [sad_pkg::SAD_IDX_W-1:0] reg_idx;
  modport dec (input addr, output cycle, output reg_idx);
  modport use_side (output addr, input cycle, input reg_idx);
endinterface : sad_dec_if

// >>> design/sad_decoder.sv
`timescale 1ns/1ps
module sad_decoder (
  sad_dec_if.dec d
);
  import sad_pkg::*;
  always_comb begin
    d.cycle = SAD_CYC_MEM;
    d.reg_idx = '0;
    if (d.addr == SAD_VIDEO_ADDR) begin // R1
      d.cycle = SAD_CYC_VIDEO;
    end else if (d.addr >= SAD_CTRL_BASE && d.addr <= SAD_CTRL_TOP) begin // R3
      // unaligned control addresses are not registers
      if (d.addr[1:0] == 2'h0) begin // R4
        d.cycle = SAD_CYC_CTRL;
        d.reg_idx = d.addr[SAD_IDX_W+1:2]; // R5
      end else begin
        d.cycle = SAD_CYC_BAD;
      end
    end
  end
endmodule : sad_decoder

// >>> design/sad_pkg.sv
// Contract
// (R1) a processor write to the video strobe address becomes a macrocell write strobe with no address.
// (R2) the macrocell register is picked from the top four or eight bits of the written data.
// (R3) control registers live from the control base through the control top address.
// (R4) every control register sits on a word-aligned address.
// (R5) the processor address goes to a decoder that picks the cycle type and register index.
// (R6) a 29-bit latched copy of the address is exported, updated on the memory clock fall.
// (R7) a latched byte/word flag is exported, updated on the memory clock fall.
// (R8) data moves on the 32-bit bus, only the low 16 bits being used in 16-bit mode.
// (R9) every reset brings the memory width back to 16-bit mode.
// (R10) with the sync strap high, processor and memory both run from the memory clock.
// (R11) the system holds the sync strap low when separate clocks are supplied.
// (R12) with the test pin low, pin functions follow the three interrupt pins.
// (R13) the system never drives the test pin low in normal use.
// (R14) with the sync strap high, the processor clock input is tied to a fixed level.
package sad_pkg;
  localparam logic [31:0] SAD_VIDEO_ADDR = 32'h03400000;
  localparam logic [31:0] SAD_CTRL_BASE = 32'h03200000;
  localparam logic [31:0] SAD_CTRL_TOP = 32'h032001F8;
  localparam int SAD_LA_W = 29;
  localparam int SAD_IDX_W = 7;
  localparam logic SAD_WIDE_RST = 1'b0;
  typedef enum logic [3:0] {
    SAD_CYC_MEM = 4'h1,
    SAD_CYC_CTRL = 4'h2,
    SAD_CYC_VIDEO = 4'h4,
    SAD_CYC_BAD = 4'h8
  } sad_cycle_e;
endpackage : sad_pkg

// >>> design/sad_top.sv
`timescale 1ns/1ps
module sad_top (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // processor side, same clock
  input wire logic [31:0] cpu_addr,
  input wire logic cpu_valid,
  input wire logic cpu_write,
  input wire logic byte_word_flag,
  input wire logic [31:0] cpu_wdata,
  input wire logic wide_mode_set,
  input wire logic wide_mode_val,
  input wire logic video_sel_wide,
  // pins
  input wire logic memory_clock_in,
  input wire logic processor_clock_in,
  input wire logic sync_select_strap,
  input wire logic test_mode_pin,
  input wire logic interrupt_pin_three,
  input wire logic interrupt_pin_six,
  input wire logic interrupt_pin_eight,
  input wire logic [31:0] data_in,
  // external bus
  output logic [sad_pkg::SAD_LA_W-1:0] latched_address_out,
  output logic latched_byte_word_flag,
  output logic [31:0] data_out,
  output logic [31:0] data_oe,
  // macrocell and register group
  output logic video_wr_strobe,
  output logic [7:0] video_reg_sel,
  output logic [31:0] video_wdata,
  output logic ctrl_sel,
  output logic [sad_pkg::SAD_IDX_W-1:0] ctrl_idx,
  output logic [31:0] cpu_rdata,
  // clocking and test
  output logic wide_mode,
  output logic processor_fast_clock,
  output logic test_active,
  output logic [2:0] test_select
);
  import sad_pkg::*;
  sad_dec_if dif();
  assign dif.addr = cpu_addr;
  sad_decoder u_dec (.d(dif)); // R5
  // pin synchronisers: three stages, change accepted when stages two and three agree
  logic [2:0] mclk_s, pclk_s, strap_s, test_s, i3_s, i6_s, i8_s;
  logic mclk_f, pclk_f, strap_f, test_f, i3_f, i6_f, i8_f;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {mclk_s, pclk_s, strap_s, i3_s, i6_s, i8_s} <= '0;
      test_s <= 3'h7;
    end else if (clk_en) begin
      mclk_s <= {mclk_s[1:0], memory_clock_in};
      pclk_s <= {pclk_s[1:0], processor_clock_in};
      strap_s <= {strap_s[1:0], sync_select_strap};
      test_s <= {test_s[1:0], test_mode_pin};
      i3_s <= {i3_s[1:0], interrupt_pin_three};
      i6_s <= {i6_s[1:0], interrupt_pin_six};
      i8_s <= {i8_s[1:0], interrupt_pin_eight};
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {mclk_f, pclk_f, strap_f, i3_f, i6_f, i8_f} <= '0;
      test_f <= 1'b1;
    end else if (clk_en) begin
      if (mclk_s[1] == mclk_s[2]) mclk_f <= mclk_s[2];
      if (pclk_s[1] == pclk_s[2]) pclk_f <= pclk_s[2];
      if (strap_s[1] == strap_s[2]) strap_f <= strap_s[2];
      if (test_s[1] == test_s[2]) test_f <= test_s[2];
      if (i3_s[1] == i3_s[2]) i3_f <= i3_s[2];
      if (i6_s[1] == i6_s[2]) i6_f <= i6_s[2];
      if (i8_s[1] == i8_s[2]) i8_f <= i8_s[2];
    end
  end
  logic mclk_d;
  logic mclk_fall;
  always_ff @(posedge sys_clk) begin
    if (rst) mclk_d <= 1'b0;
    else if (clk_en) mclk_d <= mclk_f;
  end
  assign mclk_fall = mclk_d & ~mclk_f;
  // address and flag latches follow the memory clock's falling edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      latched_address_out <= '0;
      latched_byte_word_flag <= 1'b0;
    end else if (clk_en && mclk_fall) begin
      latched_address_out <= cpu_addr[SAD_LA_W-1:0]; // R6
      latched_byte_word_flag <= byte_word_flag; // R7
    end
  end
  // memory width: narrow after every reset so boot works from either rom width
  always_ff @(posedge sys_clk) begin
    if (rst) wide_mode <= SAD_WIDE_RST; // R9
    else if (clk_en && wide_mode_set) wide_mode <= wide_mode_val;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      data_out <= '0;
      data_oe <= '0;
      cpu_rdata <= '0;
    end else if (clk_en) begin
      if (cpu_valid && cpu_write && dif.cycle == SAD_CYC_MEM) begin
        data_out <= wide_mode ? cpu_wdata : {16'h0000, cpu_wdata[15:0]}; // R8
        data_oe <= wide_mode ? 32'hFFFFFFFF : 32'h0000FFFF; // R8
      end else begin
        data_oe <= '0;
      end
      cpu_rdata <= wide_mode ? data_in : {16'h0000, data_in[15:0]}; // R8
    end
  end
  // macrocell sees data only; its register select comes from the top data bits
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      video_wr_strobe <= 1'b0;
      video_reg_sel <= '0;
      video_wdata <= '0;
      ctrl_sel <= 1'b0;
      ctrl_idx <= '0;
    end else if (clk_en) begin
      video_wr_strobe <= cpu_valid && cpu_write && dif.cycle == SAD_CYC_VIDEO; // R1
      if (cpu_valid && cpu_write && dif.cycle == SAD_CYC_VIDEO) begin
        video_wdata <= cpu_wdata;
        video_reg_sel <= video_sel_wide ? cpu_wdata[31:24] : {4'h0, cpu_wdata[31:28]}; // R2
      end
      ctrl_sel <= cpu_valid && dif.cycle == SAD_CYC_CTRL; // R3
      ctrl_idx <= dif.reg_idx; // R4
    end
  end
  // strap high: processor clock follows memory clock, processor pin ignored
  always_ff @(posedge sys_clk) begin
    if (rst) processor_fast_clock <= 1'b0;
    else if (clk_en) processor_fast_clock <= strap_f ? mclk_f : pclk_f; // R10
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      test_active <= 1'b0;
      test_select <= '0;
    end else if (clk_en) begin
      test_active <= ~test_f; // R12
      test_select <= test_f ? 3'h0 : {i8_f, i6_f, i3_f}; // R12
    end
  end
  // assertions
  property p_video_strobe;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && cpu_valid && cpu_write && cpu_addr == SAD_VIDEO_ADDR) |=> video_wr_strobe;
  endproperty
  a_video_strobe: assert property (p_video_strobe) else $error("video strobe missing"); // R1
  property p_video_sel;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && cpu_valid && cpu_write && cpu_addr == SAD_VIDEO_ADDR && !video_sel_wide)
      |=> video_reg_sel == {4'h0, $past(cpu_wdata[31:28])};
  endproperty
  a_video_sel: assert property (p_video_sel) else $error("video select wrong"); // R2
  property p_ctrl_range;
    @(posedge sys_clk) disable iff (rst)
    // a frozen select is a stale pulse, so only a select made on a live edge is judged
    (ctrl_sel && $past(clk_en))
      |-> $past(cpu_addr) >= SAD_CTRL_BASE && $past(cpu_addr) <= SAD_CTRL_TOP;
  endproperty
  a_ctrl_range: assert property (p_ctrl_range) else $error("control select out of range"); // R3
  property p_ctrl_align;
    @(posedge sys_clk) disable iff (rst)
    (ctrl_sel && $past(clk_en))
      |-> $past(cpu_addr[1:0]) == 2'h0 && ctrl_idx == $past(cpu_addr[8:2]);
  endproperty
  a_ctrl_align: assert property (p_ctrl_align) else $error("control index wrong"); // R4
  property p_latch;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && mclk_fall) |=> latched_address_out == $past(cpu_addr[28:0])
      && latched_byte_word_flag == $past(byte_word_flag);
  endproperty
  a_latch: assert property (p_latch) else $error("latch not updated"); // R6
  property p_latch_hold;
    @(posedge sys_clk) disable iff (rst)
    !(clk_en && mclk_fall) |=> $stable(latched_address_out) && $stable(latched_byte_word_flag);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch moved off edge"); // R7
  property p_narrow;
    @(posedge sys_clk) disable iff (rst)
    !wide_mode |-> data_oe[31:16] == 16'h0000;
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper lanes driven in narrow mode"); // R8
  property p_reset_narrow;
    @(posedge sys_clk) rst |=> !wide_mode;
  endproperty
  a_reset_narrow: assert property (p_reset_narrow) else $error("not narrow after reset"); // R9
  property p_sync_clk;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && strap_f) |=> processor_fast_clock == $past(mclk_f);
  endproperty
  a_sync_clk: assert property (p_sync_clk) else $error("sync clock wrong"); // R10
  property p_test;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && test_f) |=> !test_active && test_select == 3'h0;
  endproperty
  a_test: assert property (p_test) else $error("test mode in normal use"); // R12
  // the strobe may only follow a taken video write, never a read or another address
  property p_video_only;
    @(posedge sys_clk) disable iff (rst)
    (video_wr_strobe && $past(clk_en))
      |-> $past(cpu_valid && cpu_write && cpu_addr == SAD_VIDEO_ADDR);
  endproperty
  a_video_only: assert property (p_video_only) else $error("stray video strobe"); // R1
  // a memory cycle is any write away from the video address and the control range
  property p_mem_lanes;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && cpu_valid && cpu_write && cpu_addr != SAD_VIDEO_ADDR
      && (cpu_addr < SAD_CTRL_BASE || cpu_addr > SAD_CTRL_TOP))
      |=> data_oe == ($past(wide_mode) ? 32'hFFFFFFFF : 32'h0000FFFF)
      && data_out[15:0] == $past(cpu_wdata[15:0]);
  endproperty
  a_mem_lanes: assert property (p_mem_lanes) else $error("memory write lanes wrong"); // R8
  // a low enable freezes the block, so outputs must hold
  property p_freeze;
    @(posedge sys_clk) disable iff (rst)
    !clk_en |=> $stable(video_wr_strobe) && $stable(ctrl_sel) && $stable(data_oe)
      && $stable(wide_mode) && $stable(test_active) && $stable(processor_fast_clock);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  c_video: cover property (@(posedge sys_clk) video_wr_strobe);
  c_ctrl: cover property (@(posedge sys_clk) ctrl_sel);
  c_wide: cover property (@(posedge sys_clk) wide_mode && data_oe == 32'hFFFFFFFF);
  c_test: cover property (@(posedge sys_clk) test_active);
  c_sync: cover property (@(posedge sys_clk) strap_f && processor_fast_clock);
endmodule : sad_top

// >>> verification/sad_mem_model.sv
`timescale 1ns/1ps
module sad_mem_model (
  // strap seen and bus lines driven by the device
  input wire logic sync_select_strap,
  input wire logic [31:0] data_oe,
  // clocks and memory data toward the device
  output logic memory_clock_in,
  output logic processor_clock_in,
  output logic [31:0] data_in
);
  localparam logic [31:0] SAD_ROM_WORD = 32'hA5C35AF0;
  logic cpu_clk_free;
  initial begin
    memory_clock_in = 1'b0;
    cpu_clk_free = 1'b0;
  end
  // rates unrelated to sys_clk so the pin synchronisers see every phase
  always #10.3 memory_clock_in = ~memory_clock_in;
  always #7.1 cpu_clk_free = ~cpu_clk_free;
  // separate processor clock only while the strap is low, tied low otherwise
  assign processor_clock_in = sync_select_strap ? 1'b0 : cpu_clk_free;
  // lines the device drives read back inverted, so a stale value never passes
  assign data_in = SAD_ROM_WORD ^ data_oe;
endmodule : sad_mem_model

// >>> verification/system_address_decode_test.sv
`timescale 1ns/1ps
module system_address_decode_test;
  import sad_pkg::*;
  logic sys_clk = 0, rst = 1, clk_en = 1, cpu_valid = 0, cpu_write = 0, byte_word_flag = 0;
  logic [31:0] cpu_addr = 0, cpu_wdata = 0, data_in, data_out, data_oe, video_wdata, cpu_rdata;
  logic wide_mode_set = 0, wide_mode_val = 0, video_sel_wide = 0, sync_select_strap = 0;
  logic test_mode_pin = 1, int3 = 1, int6 = 1, int8 = 1, memory_clock_in, processor_clock_in;
  logic [SAD_LA_W-1:0] latched_address_out;
  logic [SAD_IDX_W-1:0] ctrl_idx;
  logic [7:0] video_reg_sel;
  logic [2:0] test_select;
  logic latched_byte_word_flag, video_wr_strobe, ctrl_sel, wide_mode, processor_fast_clock;
  logic test_active;
  int n_fail = 0, checks_done = 0, cycles = 0;
  always #2 sys_clk = ~sys_clk;
  sad_top dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .cpu_addr(cpu_addr),
    .cpu_valid(cpu_valid), .cpu_write(cpu_write), .byte_word_flag(byte_word_flag),
    .cpu_wdata(cpu_wdata), .wide_mode_set(wide_mode_set), .wide_mode_val(wide_mode_val),
    .video_sel_wide(video_sel_wide), .memory_clock_in(memory_clock_in),
    .processor_clock_in(processor_clock_in), .sync_select_strap(sync_select_strap),
    .test_mode_pin(test_mode_pin), .interrupt_pin_three(int3), .interrupt_pin_six(int6),
    .interrupt_pin_eight(int8), .data_in(data_in), .latched_address_out(latched_address_out),
    .latched_byte_word_flag(latched_byte_word_flag), .data_out(data_out), .data_oe(data_oe),
    .video_wr_strobe(video_wr_strobe), .video_reg_sel(video_reg_sel),
    .video_wdata(video_wdata), .ctrl_sel(ctrl_sel), .ctrl_idx(ctrl_idx), .cpu_rdata(cpu_rdata),
    .wide_mode(wide_mode), .processor_fast_clock(processor_fast_clock),
    .test_active(test_active), .test_select(test_select));
  sad_mem_model mem (.sync_select_strap(sync_select_strap), .data_oe(data_oe),
    .memory_clock_in(memory_clock_in), .processor_clock_in(processor_clock_in),
    .data_in(data_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic do_reset();
    rst = 1;
    repeat (4) @(posedge sys_clk);
    #1 rst = 0;
  endtask : do_reset
  // one request taken at the next edge; answer visible on return
  task automatic req(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    #1 cpu_addr = a;
    cpu_valid = 1;
    cpu_write = w;
    cpu_wdata = d;
    @(posedge sys_clk);
    #1 cpu_valid = 0;
    cpu_write = 0;
  endtask : req
  task automatic test_video();
    for (int w = 0; w < 2; w++) begin
      video_sel_wide = w[0];
      req(SAD_VIDEO_ADDR, 1, 32'hAB123456);
      check(video_wr_strobe, 1);
      check(video_reg_sel, w ? 32'hAB : 32'h0A);
      check(video_wdata, 32'hAB123456);
      @(posedge sys_clk);
      #1 check(video_wr_strobe, 0);
    end
    req(SAD_VIDEO_ADDR, 0, 32'hAB123456);
    check(video_wr_strobe, 0);
    $display("video strobe test ended");
  endtask : test_video
  task automatic test_ctrl();
    logic [31:0] a[4] = '{SAD_CTRL_BASE, SAD_CTRL_TOP, SAD_CTRL_BASE + 2, SAD_CTRL_TOP + 8};
    for (int i = 0; i < 4; i++) begin
      req(a[i], 1, 32'h000000C3);
      check(ctrl_sel, i < 2);
      if (i < 2) check(ctrl_idx, i ? 32'h7E : 32'h00);
      if (i == 2) check(data_oe, 0);
      if (i == 3) check(data_oe, 32'h0000FFFF);
    end
    $display("control range test ended");
  endtask : test_ctrl
  task automatic test_latch();
    cpu_addr = 32'hF5A5C3E4;
    byte_word_flag = 1;
    cpu_valid = 1;
    for (int i = 0; i < 40 && latched_address_out !== 29'h15A5C3E4; i++) begin
      @(posedge sys_clk);
      #1;
    end
    check(latched_address_out, 29'h15A5C3E4);
    check(latched_byte_word_flag, 1);
    cpu_valid = 0;
    $display("latch test ended");
  endtask : test_latch
  task automatic test_freeze();
    logic [SAD_LA_W-1:0] held;
    held = latched_address_out;
    clk_en = 0;
    cpu_addr = 32'h0ABCDEF0;
    repeat (12) @(posedge sys_clk);
    #1 check(latched_address_out, held);
    req(SAD_VIDEO_ADDR, 1, 32'h5A000000);
    check(video_wr_strobe, 0);
    clk_en = 1;
    @(posedge sys_clk);
    #1 check(video_wr_strobe, 0);
    $display("freeze test ended");
  endtask : test_freeze
  task automatic test_sync();
    int ones = 0;
    int zeros = 0;
    // processor pin is tied low by the partner while the strap is high
    sync_select_strap = 1;
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      #1;
      if (processor_fast_clock) ones++;
      else zeros++;
    end
    check(ones > 0 && zeros > 0, 1);
    sync_select_strap = 0;
    repeat (8) @(posedge sys_clk);
    $display("sync clock test ended");
  endtask : test_sync
  task automatic test_width();
    req(32'h00001000, 0, 0);
    check(cpu_rdata, 32'h00005AF0);
    req(32'h00002000, 1, 32'h12345678);
    check(data_oe, 32'h0000FFFF);
    check(data_out, 32'h00005678);
    @(posedge sys_clk);
    #1 check(data_oe, 0);
    wide_mode_set = 1;
    wide_mode_val = 1;
    @(posedge sys_clk);
    #1 wide_mode_set = 0;
    req(32'h00001000, 0, 0);
    check(wide_mode, 1);
    check(cpu_rdata, 32'hA5C35AF0);
    req(32'h00002000, 1, 32'h12345678);
    check(data_oe, 32'hFFFFFFFF);
    check(data_out, 32'h12345678);
    do_reset();
    check(wide_mode, 0);
    check(data_oe, 0);
    $display("width test ended");
  endtask : test_width
  task automatic test_pins();
    // low test pin only here; otherwise held high as in normal use
    test_mode_pin = 0;
    {int8, int6, int3} = 3'b101;
    repeat (8) @(posedge sys_clk);
    #1 check(test_active, 1);
    check(test_select, 3'b101);
    test_mode_pin = 1;
    repeat (8) @(posedge sys_clk);
    #1 check(test_active, 0);
    check(test_select, 0);
    $display("test pin test ended");
  endtask : test_pins
  initial begin
    do_reset();
    check(wide_mode, 0);
    test_video();
    test_ctrl();
    test_latch();
    test_freeze();
    test_width();
    test_sync();
    test_pins();
    conclude();
  end
endmodule : system_address_decode_test
